// [dbp_array.sv]
// one storage array with nine-bit lane writes
`timescale 1ns/1ps
`include "dbp_consts.svh"
module dbp_array
  import dbp_pkg::*;
#(
  parameter int DATA_W = `DBP_DATA_W_NARROW,
  parameter int ADDR_W = `DBP_ADDR_W_NARROW
)
(
  input wire logic i_mclk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [DATA_W/`DBP_LANE_W-1:0] i_lane_sel_n,
  output logic [DATA_W-1:0] o_rdata
);
  localparam int LANES = DATA_W / `DBP_LANE_W;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // storage has no reset, like the real cells
  always_ff @(posedge i_mclk)
  begin
    if (i_ce && i_we)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (!i_lane_sel_n[l])
        begin
          mem[i_addr][l*`DBP_LANE_W +: `DBP_LANE_W] <=
            i_wdata[l*`DBP_LANE_W +: `DBP_LANE_W];
        end
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && i_re)
    begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule

// [dbp_consts.svh]
// constants for the two-word-burst memory port
`ifndef DBP_CONSTS_SVH
`define DBP_CONSTS_SVH
`define DBP_LANE_W 9
`define DBP_DATA_W_NARROW 18
`define DBP_DATA_W_WIDE 36
`define DBP_ADDR_W_NARROW 19
`define DBP_ADDR_W_WIDE 18
`define DBP_SYNC_STAGES 2
`define DBP_MCLK_PERIOD_NS 40
`endif

// [dbp_ctl_model.sv]
// controller model: link clocks and commands
`timescale 1ns/1ps
module dbp_ctl_model
(
  input wire logic i_mclk,
  output logic o_k,
  output logic o_k_n,
  output logic o_strobe_n,
  output logic o_rd_nwr,
  output logic [3:0] o_addr,
  output logic [17:0] o_dq,
  output logic [1:0] o_sel_n
);
  assign o_k_n = ~o_k;
  // odd offset keeps k edges clear of mclk edges
  initial
  begin
    o_k = 1'h0;
    o_strobe_n = 1'h1;
    o_rd_nwr = 1'h0;
    o_addr = 4'h0;
    o_dq = 18'h0;
    o_sel_n = 2'h3;
    #7;
    forever #160 o_k = ~o_k;
  end
  // changes sit midway between edges, pins are synced
  task automatic cmd(input logic rd, input logic [3:0] a,
    input logic [17:0] d0, input logic [17:0] d1,
    input logic [1:0] s0, input logic [1:0] s1);
    @(posedge o_k_n);
    #80;
    @(negedge i_mclk);
    o_strobe_n = 1'h0;
    o_rd_nwr = rd;
    o_addr = a;
    o_dq = d0;
    o_sel_n = s0;
    @(posedge o_k);
    #80;
    @(negedge i_mclk);
    o_strobe_n = 1'h1;
    o_addr = ~a;
    o_dq = d1;
    o_sel_n = s1;
  endtask
endmodule

// [dbp_ddr_burst2_sram_port.sv]
// memory-side port of a two-word-burst ddr static memory
`timescale 1ns/1ps
`include "dbp_consts.svh"
module dbp_ddr_burst2_sram_port
  import dbp_pkg::*;
#(
  parameter int DATA_W = `DBP_DATA_W_NARROW,
  parameter int ADDR_W = `DBP_ADDR_W_NARROW
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic i_bus_cycle_strobe_n,
  input wire logic i_rd_nwr,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic [DATA_W/`DBP_LANE_W-1:0] i_byte_lane_write_sel_n,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_output_valid_flag,
  output logic o_echo_clock,
  output logic o_echo_clock_n
);
  localparam int LANES = DATA_W / `DBP_LANE_W;
  localparam int SYNC_W = 4 + ADDR_W + DATA_W + LANES;

  // refuse widths the lane logic cannot serve
  if (!((DATA_W == `DBP_DATA_W_NARROW) || (DATA_W == `DBP_DATA_W_WIDE)))
  begin : g_bad_width
    $error("data width must be 18 or 36");
  end
  if (ADDR_W < 1)
  begin : g_bad_addr
    $error("address width must be at least 1");
  end

  // all pins cross together, so word and select stay paired
  logic [SYNC_W-1:0] pins_s;
  dbp_clk_pair_t clk_s;
  dbp_clk_pair_t clk_prev;
  dbp_cmd_t cmd_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] dq_s;
  logic [LANES-1:0] sel_s;

  dbp_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_async({i_k, i_k_n, i_bus_cycle_strobe_n, i_rd_nwr, i_addr, i_dq,
      i_byte_lane_write_sel_n}),
    .o_sync(pins_s)
  );

  assign {clk_s, cmd_s, addr_s, dq_s, sel_s} = pins_s;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      clk_prev <= '0;
    end
    else if (i_ce)
    begin
      clk_prev <= clk_s;
    end
  end

  logic k_rise;
  logic k_n_rise;
  logic load_rd;
  logic load_wr;
  assign k_rise = clk_s.k && !clk_prev.k;
  assign k_n_rise = clk_s.k_n && !clk_prev.k_n;
  // strobe only counts on the positive rise
  assign load_rd = k_rise && !cmd_s.bus_cycle_strobe_n && cmd_s.rd_nwr;
  assign load_wr = k_rise && !cmd_s.bus_cycle_strobe_n && !cmd_s.rd_nwr;

  // write second word pending for the negative rise
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else if (i_ce)
    begin
      if (load_wr)
      begin
        wr_pend <= 1'b1;
        wr_addr <= addr_s;
      end
      else if (k_n_rise)
      begin
        wr_pend <= 1'b0;
      end
    end
  end

  logic arr0_we;
  logic arr1_we;
  logic [ADDR_W-1:0] arr1_addr;
  logic [DATA_W-1:0] arr0_q;
  logic [DATA_W-1:0] arr1_q;
  assign arr0_we = load_wr;
  assign arr1_we = k_n_rise && wr_pend && !load_wr;
  assign arr1_addr = arr1_we ? wr_addr : addr_s;

  // two equal arrays, one per burst word
  dbp_array #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_arr0 (
    .i_mclk(i_mclk),
    .i_ce(i_ce),
    .i_we(arr0_we),
    .i_re(load_rd),
    .i_addr(addr_s),
    .i_wdata(dq_s),
    .i_lane_sel_n(sel_s),
    .o_rdata(arr0_q)
  );

  dbp_array #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_arr1 (
    .i_mclk(i_mclk),
    .i_ce(i_ce),
    .i_we(arr1_we),
    .i_re(load_rd),
    .i_addr(arr1_addr),
    .i_wdata(dq_s),
    .i_lane_sel_n(sel_s),
    .o_rdata(arr1_q)
  );

  // read pipeline: array at load, stage at next rise, launch after
  logic rd_issued;
  logic stage_v;
  logic [DATA_W-1:0] stage_w0;
  logic [DATA_W-1:0] stage_w1;
  logic [DATA_W-1:0] hold_w1;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_issued <= 1'b0;
      stage_v <= 1'b0;
      stage_w0 <= '0;
      stage_w1 <= '0;
    end
    else if (i_ce && k_rise)
    begin
      rd_issued <= load_rd;
      stage_v <= rd_issued;
      stage_w0 <= arr0_q;
      stage_w1 <= arr1_q;
    end
  end

  dbp_out_phase_t phase;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      phase <= DBP_OUT_IDLE;
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      o_output_valid_flag <= 1'b0;
      hold_w1 <= '0;
    end
    else if (i_ce)
    begin
      case (phase)
        DBP_OUT_IDLE:
        begin
          if (k_rise && stage_v)
          begin
            phase <= DBP_OUT_W0;
            o_dq <= stage_w0;
            hold_w1 <= stage_w1;
            o_dq_oe <= 1'b1;
            o_output_valid_flag <= 1'b1;
          end
        end
        DBP_OUT_W0:
        begin
          if (k_n_rise)
          begin
            phase <= DBP_OUT_W1;
            o_dq <= hold_w1;
          end
        end
        DBP_OUT_W1:
        begin
          if (k_rise)
          begin
            if (stage_v)
            begin
              phase <= DBP_OUT_W0;
              o_dq <= stage_w0;
              hold_w1 <= stage_w1;
            end
            else
            begin
              // no read behind this one, so let go of the bus
              phase <= DBP_OUT_IDLE;
              o_dq_oe <= 1'b0;
              o_output_valid_flag <= 1'b0;
            end
          end
        end
        default:
        begin
          phase <= DBP_OUT_IDLE;
          o_dq_oe <= 1'b0;
          o_output_valid_flag <= 1'b0;
        end
      endcase
    end
  end

  // echo clocks follow the sampled input clocks, free running
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_echo_clock <= 1'b0;
      o_echo_clock_n <= 1'b0;
    end
    else if (i_ce)
    begin
      o_echo_clock <= clk_s.k;
      o_echo_clock_n <= clk_s.k_n;
    end
  end
endmodule

// [dbp_pkg.sv]
// types for the two-word-burst memory port
package dbp_pkg;
  typedef enum logic [1:0] {
    DBP_OUT_IDLE = 2'b00,
    DBP_OUT_W0 = 2'b01,
    DBP_OUT_W1 = 2'b10
  } dbp_out_phase_t;
  typedef struct packed {
    logic bus_cycle_strobe_n;
    logic rd_nwr;
  } dbp_cmd_t;
  typedef struct packed {
    logic k;
    logic k_n;
  } dbp_clk_pair_t;
endpackage

// [dbp_port_chk.sv]
// checker for the burst memory port
`timescale 1ns/1ps
module dbp_port_chk
  import dbp_pkg::*;
#(
  parameter int DATA_W = 18
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic o_dq_oe,
  input wire logic o_output_valid_flag,
  input wire logic o_echo_clock,
  input wire logic o_echo_clock_n
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  valid_tracks_oe_a:
    assert property (o_output_valid_flag == o_dq_oe)
    else $error("valid flag and oe differ");
  echo_k_a:
    assert property ($rose(o_echo_clock) |-> $past(i_k, 3))
    else $error("echo clock without k");
  echo_kn_a:
    assert property ($rose(o_echo_clock_n) |-> $past(i_k_n, 3))
    else $error("echo clock n without k_n");
  oe_on_k_a:
    assert property ($rose(o_dq_oe) |-> $rose(o_echo_clock))
    else $error("oe rose off a k rise");
  oe_off_k_a:
    assert property ($fell(o_dq_oe) |-> $rose(o_echo_clock))
    else $error("oe fell off a k rise");
  burst_len_a:
    assert property ($rose(o_dq_oe) |-> o_dq_oe [*6])
    else $error("read burst too short");
  dq_hold_a:
    assert property (o_dq_oe && $past(o_dq_oe) && $stable(o_echo_clock)
      && $stable(o_echo_clock_n) |-> $stable(o_dq))
    else $error("dq moved between clock edges");
  word_edge_a:
    assert property (o_dq_oe && $changed(o_dq)
      |-> $rose(o_echo_clock) || $rose(o_echo_clock_n))
    else $error("dq word launched off edge");
endmodule
bind dbp_ddr_burst2_sram_port dbp_port_chk #(.DATA_W(DATA_W)) i_dbp_port_chk
  (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_k(i_k), .i_k_n(i_k_n),
  .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_output_valid_flag(o_output_valid_flag),
  .o_echo_clock(o_echo_clock), .o_echo_clock_n(o_echo_clock_n));

// [dbp_sync.sv]
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module dbp_sync
  import dbp_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// [tb_dbp_ddr_burst2_sram_port.sv]
// testbench for the burst memory port
`timescale 1ns/1ps
module tb_dbp_ddr_burst2_sram_port
  import dbp_pkg::*;
;
  logic mclk, nrst, oe, vld, ek, ekn;
  wire logic k, k_n, ldn, rd;
  wire logic [3:0] addr;
  wire logic [17:0] din;
  wire logic [1:0] sel;
  logic [17:0] q;
  logic [17:0] m0 [16];
  logic [17:0] m1 [16];
  int fail_count, check_count;
  dbp_ctl_model i_dbp_ctl_model (.i_mclk(mclk), .o_k(k), .o_k_n(k_n),
    .o_strobe_n(ldn), .o_rd_nwr(rd), .o_addr(addr), .o_dq(din),
    .o_sel_n(sel));
  dbp_ddr_burst2_sram_port #(.DATA_W(18), .ADDR_W(4))
    i_dbp_ddr_burst2_sram_port (.i_mclk(mclk), .i_nrst(nrst), .i_ce(1'h1),
    .i_k(k), .i_k_n(k_n), .i_bus_cycle_strobe_n(ldn), .i_rd_nwr(rd),
    .i_addr(addr), .i_dq(din), .i_byte_lane_write_sel_n(sel), .o_dq(q),
    .o_dq_oe(oe), .o_output_valid_flag(vld), .o_echo_clock(ek),
    .o_echo_clock_n(ekn));
  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(string n, logic [17:0] e, logic [17:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] n,
    logic [1:0] s);
    merge = o;
    for (int l = 0; l < 2; l++)
    begin
      if (!s[l])
      begin
        merge[9*l +: 9] = n[9*l +: 9];
      end
    end
  endfunction
  task automatic wr(logic [3:0] a, logic [17:0] d0, logic [17:0] d1,
    logic [1:0] s0, logic [1:0] s1);
    i_dbp_ctl_model.cmd(1'h0, a, d0, d1, s0, s1);
    m0[a] = merge(m0[a], d0, s0);
    m1[a] = merge(m1[a], d1, s1);
  endtask
  task automatic rd_chk(logic [3:0] a);
    i_dbp_ctl_model.cmd(1'h1, a, 18'($urandom), 18'($urandom), 2'h0, 2'h0);
    @(posedge k);
    @(posedge k);
    #230;
    chk("word0", m0[a], q);
    chk("oe", 18'h1, {17'h0, oe});
    chk("valid", 18'h1, {17'h0, vld});
    @(posedge k);
    #20;
    chk("word1", m1[a], q);
    #160;
    chk("oe off", 18'h0, {17'h0, oe});
  endtask
  // two reads back to back: the bus must stay driven between the bursts
  task automatic rd_pair(logic [3:0] a, logic [3:0] b);
    i_dbp_ctl_model.cmd(1'h1, a, 18'h0, 18'h0, 2'h3, 2'h3);
    i_dbp_ctl_model.cmd(1'h1, b, 18'h0, 18'h0, 2'h3, 2'h3);
    @(posedge k);
    #230;
    chk("pair a word0", m0[a], q);
    @(posedge k);
    #20;
    chk("pair a word1", m1[a], q);
    #210;
    chk("pair b word0", m0[b], q);
    chk("pair oe", 18'h1, {17'h0, oe});
    chk("pair valid", 18'h1, {17'h0, vld});
    @(posedge k);
    #20;
    chk("pair b word1", m1[b], q);
    #160;
    chk("pair oe off", 18'h0, {17'h0, oe});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fail_count++;
    conclude();
  end
  initial
  begin
    nrst = 1'h0;
    fail_count = 0;
    check_count = 0;
    void'($urandom(241));
    repeat (16) @(negedge mclk);
    nrst = 1'h1;
    repeat (4) @(negedge mclk);
    chk("idle oe", 18'h0, {17'h0, oe});
    for (int a = 0; a < 16; a++)
      wr(4'(a), 18'($urandom), 18'($urandom), 2'h0, 2'h0);
    $display("test fill done");
    wr(4'h5, 18'h3FFFF, 18'h3FFFF, 2'h3, 2'h3);
    for (int i = 0; i < 24; i++)
      wr(4'($urandom), 18'($urandom), 18'($urandom), 2'($urandom),
        2'($urandom));
    $display("test lane writes done");
    for (int a = 0; a < 16; a++)
      rd_chk(4'(a));
    $display("test reads done");
    rd_pair(4'($urandom), 4'($urandom));
    $display("test back to back reads done");
    // reset while idle: outputs clear, stored words survive
    @(negedge mclk);
    nrst = 1'h0;
    repeat (2) @(negedge mclk);
    chk("reset q", 18'h0, q);
    chk("reset flags", 18'h0, {14'h0, oe, vld, ek, ekn});
    nrst = 1'h1;
    repeat (4) @(negedge mclk);
    rd_pair(4'h3, 4'hC);
    $display("test mid reset done");
    conclude();
  end
endmodule
